// ### hcr_pkg.sv
// Shared constants for the host command reinit port: link register map,
// command codes, host APB map, timing counts and host sequencer states.
// Assumes a single 250 MHz pclk shared by both ends.
package hcr_pkg;
   localparam int LINK_AW = 8;
   localparam int DW = 32;
   localparam int APB_AW = 8;
   localparam int NPARAM = 4;
   localparam int NSTICKY = 5;

   localparam logic [7:0] OFS_PAGE = 8'h00;
   localparam logic [7:0] OFS_POWER = 8'h02;
   localparam logic [7:0] OFS_PARAM0 = 8'h08;
   localparam logic [7:0] OFS_CMD = 8'h58;
   localparam logic [7:0] OFS_FLAG = 8'h5C;
   localparam logic [7:0] OFS_STICKY0 = 8'h60;
   localparam logic [7:0] OFS_BOOK = 8'h7F;
   localparam logic [7:0] OFS_STEP = 8'h04;

   localparam logic [7:0] PAGE_BASE = 8'h00;
   localparam logic [7:0] PAGE_CMD = 8'h1A;
   localparam logic [7:0] BOOK_BASE = 8'h00;
   localparam logic [7:0] PWR_ACTIVE = 8'h00;
   localparam logic [7:0] PWR_SHUTDOWN = 8'h02;
   localparam logic [7:0] RST_PAGE = 8'h00;
   localparam logic [7:0] RST_BOOK = 8'h00;
   localparam logic [7:0] RST_POWER = PWR_SHUTDOWN;

   localparam logic [31:0] CMD_CLEAR = 32'h0000_000D;
   localparam logic [31:0] CMD_REINIT = 32'h0000_000E;
   localparam logic [31:0] FLAG_NEW = 32'h0000_0001;

   localparam logic [2:0] LEN_BYTE = 3'h1;
   localparam logic [2:0] LEN_WORD = 3'h4;

   localparam logic [7:0] APB_CMD = 8'h00;
   localparam logic [7:0] APB_STATUS = 8'h04;
   localparam logic [7:0] APB_LAST = 8'h08;
   localparam int ST_BUSY = 0;
   localparam int ST_DONE = 1;
   localparam int ST_ERR = 2;
   localparam int ST_STATE = 4;

   localparam int CLK_PERIOD_NS = 4;
   localparam int SETTLE_TIME_NS = 5_000_000;
   localparam int EXEC_TIME_NS = 5_000_000;
   localparam int SETTLE_CYCLES =
      (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int EXEC_CYCLES = EXEC_TIME_NS / CLK_PERIOD_NS;

   typedef enum logic [3:0] {
      HS_IDLE = 4'h0,
      HS_PG0 = 4'h1,
      HS_BK0 = 4'h3,
      HS_ACT = 4'h2,
      HS_SETTLE = 4'h6,
      HS_PG1A = 4'h7,
      HS_CMD = 4'h5,
      HS_FLAG = 4'h4,
      HS_POLL = 4'hC,
      HS_PG0B = 4'hD,
      HS_SHUT = 4'hF
   } hcr_state_type;
endpackage

// ### hcr_link_if.sv
// Register access link between command host and device.
// Host holds req and its fields until ack; device acks for one cycle.
`timescale 1ns/1ps
interface hcr_link_if (
   input logic pclk
);
   logic req;
   logic we;
   logic [hcr_pkg::LINK_AW-1:0] addr;
   logic [2:0] len;
   logic [hcr_pkg::DW-1:0] wdata;
   logic ack;
   logic err;
   logic [hcr_pkg::DW-1:0] rdata;

   modport dev (
      input req, we, addr, len, wdata,
      output ack, err, rdata
   );
   modport host (
      output req, we, addr, len, wdata,
      input ack, err, rdata
   );
endinterface

// ### hcr_device.sv
// Device end: book/page register window, command word and pending flag,
// parameter buffer with working copy, sticky flags.
// Assumes the link host holds each request until it sees ack.
`timescale 1ns/1ps
module hcr_device #(
   parameter int unsigned EXEC_CYCLES = hcr_pkg::EXEC_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   hcr_link_if.dev link,
   input wire logic start_mode,
   input wire logic [hcr_pkg::NSTICKY-1:0] flag_set,
   output logic [hcr_pkg::NPARAM*hcr_pkg::DW-1:0] work_params,
   output logic [hcr_pkg::NSTICKY-1:0] sticky_flags,
   output logic power_active,
   output logic cmd_busy
);
   import hcr_pkg::*;

   logic [7:0] page_q;
   logic [7:0] book_q;
   logic [7:0] power_q;
   logic [31:0] cmd_q;
   logic [31:0] code_q;
   logic flag_q;
   logic busy_q;
   logic [31:0] cnt_q;
   logic ack_q;
   logic err_q;
   logic [31:0] rdata_q;
   logic [31:0] param_q [NPARAM];
   logic [31:0] work_q [NPARAM];
   logic [NSTICKY-1:0] sticky_q;

   logic take;
   logic hit;
   logic acc_ok;
   logic wr;
   logic [2:0] need;
   logic [31:0] rd_val;
   logic sel_page;
   logic sel_book;
   logic sel_power;
   logic sel_cmd;
   logic sel_flag;
   logic [NPARAM-1:0] sel_param;
   logic done;
   logic apply;
   logic clr_sticky;
   logic win_base;
   logic win_cmd;

   assign take = ce & link.req & ~ack_q;
   assign win_base = (book_q == BOOK_BASE) & (page_q == PAGE_BASE);
   assign win_cmd = (book_q == BOOK_BASE) & (page_q == PAGE_CMD);

   always_comb begin
      sel_page = 1'b0;
      sel_book = 1'b0;
      sel_power = 1'b0;
      sel_cmd = 1'b0;
      sel_flag = 1'b0;
      sel_param = '0;
      need = LEN_BYTE;
      rd_val = 32'h0000_0000;
      if (link.addr == OFS_PAGE) begin
         sel_page = 1'b1;
         rd_val = {24'h00_0000, page_q};
      end else if (win_base && link.addr == OFS_BOOK) begin
         sel_book = 1'b1;
         rd_val = {24'h00_0000, book_q};
      end else if (win_base && link.addr == OFS_POWER) begin
         sel_power = 1'b1;
         rd_val = {24'h00_0000, power_q};
      end else if (win_cmd) begin
         need = LEN_WORD;
         if (link.addr == OFS_CMD) begin
            sel_cmd = 1'b1;
            rd_val = cmd_q;
         end else if (link.addr == OFS_FLAG) begin
            sel_flag = 1'b1;
            rd_val = {31'h0000_0000, flag_q};
         end
         for (int i = 0; i < NPARAM; i++) begin
            if (link.addr == OFS_PARAM0 + OFS_STEP * 8'(i)) begin
               sel_param[i] = 1'b1;
               rd_val = param_q[i];
            end
         end
         for (int i = 0; i < NSTICKY; i++) begin
            if (link.addr == OFS_STICKY0 + OFS_STEP * 8'(i)) begin
               rd_val = {31'h0000_0000, sticky_q[i]};
            end
         end
      end
   end

   // Sticky readouts hit too, but are read-only
   assign hit = sel_page | sel_book | sel_power | sel_cmd | sel_flag
      | (|sel_param)
      | (win_cmd && link.addr >= OFS_STICKY0
         && link.addr < OFS_STICKY0 + OFS_STEP * 8'(NSTICKY)
         && link.addr[1:0] == 2'h0);
   // Short reads would lose bytes of a wide register
   assign acc_ok = hit & (link.len == need);
   assign wr = take & link.we & acc_ok;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ack_q <= 1'b0;
         err_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
      end else if (ce) begin
         if (take) begin
            ack_q <= 1'b1;
            err_q <= ~acc_ok;
            rdata_q <= (!link.we && acc_ok) ? rd_val : 32'h0000_0000;
         end else begin
            ack_q <= 1'b0;
         end
      end
   end

   // Window select holds until rewritten
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         page_q <= RST_PAGE;
         book_q <= RST_BOOK;
      end else if (ce) begin
         if (wr && sel_page) begin
            page_q <= link.wdata[7:0];
         end
         if (wr && sel_book) begin
            book_q <= link.wdata[7:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         power_q <= RST_POWER;
      end else if (ce && wr && sel_power) begin
         power_q <= link.wdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd_q <= 32'h0000_0000;
      end else if (ce && wr && sel_cmd) begin
         cmd_q <= link.wdata;
      end
   end

   // Commands only run in active mode; shutdown mid-run lets it finish
   assign done = busy_q && (cnt_q == EXEC_CYCLES - 1);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_q <= 1'b0;
         cnt_q <= 32'h0000_0000;
         code_q <= 32'h0000_0000;
      end else if (ce) begin
         if (!busy_q && flag_q && power_q == PWR_ACTIVE) begin
            busy_q <= 1'b1;
            cnt_q <= 32'h0000_0000;
            code_q <= cmd_q;
         end else if (done) begin
            busy_q <= 1'b0;
         end else if (busy_q) begin
            cnt_q <= cnt_q + 32'h0000_0001;
         end
      end
   end

   // A host write of the flag wins over the completion clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_q <= 1'b0;
      end else if (ce) begin
         if (wr && sel_flag) begin
            flag_q <= (link.wdata == FLAG_NEW);
         end else if (done) begin
            flag_q <= 1'b0;
         end
      end
   end

   assign apply = (done && code_q == CMD_REINIT) || start_mode;
   assign clr_sticky = done && code_q == CMD_CLEAR;

   generate
      for (genvar i = 0; i < NPARAM; i++) begin : g_param
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               param_q[i] <= 32'h0000_0000;
               work_q[i] <= 32'h0000_0000;
            end else if (ce) begin
               if (wr && sel_param[i]) begin
                  param_q[i] <= link.wdata;
               end
               if (apply) begin
                  work_q[i] <= param_q[i];
               end
            end
         end
         assign work_params[i*DW +: DW] = work_q[i];
      end
      for (genvar i = 0; i < NSTICKY; i++) begin : g_sticky
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               sticky_q[i] <= 1'b0;
            end else if (ce) begin
               // New event beats the clear
               sticky_q[i] <= flag_set[i]
                  | (sticky_q[i] & ~clr_sticky);
            end
         end
      end
   endgenerate

   assign link.ack = ack_q;
   assign link.err = err_q;
   assign link.rdata = rdata_q;
   assign sticky_flags = sticky_q;
   assign power_active = (power_q == PWR_ACTIVE);
   assign cmd_busy = busy_q;
endmodule

// ### hcr_host.sv
// Host end: APB slave taking a command code, then a sequencer that runs
// the full window-select, wake, command, poll and shutdown sequence.
// Assumes the device acks every link request within finite time.
`timescale 1ns/1ps
module hcr_host #(
   parameter int unsigned SETTLE_CYCLES = hcr_pkg::SETTLE_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [hcr_pkg::APB_AW-1:0] paddr,
   input wire logic [hcr_pkg::DW-1:0] pwdata,
   output logic [hcr_pkg::DW-1:0] prdata,
   output logic pready,
   output logic pslverr,
   hcr_link_if.host link
);
   import hcr_pkg::*;

   hcr_state_type state_q;
   logic [31:0] cnt_q;
   logic [31:0] code_q;
   logic req_q;
   logic we_q;
   logic [7:0] addr_q;
   logic [2:0] len_q;
   logic [31:0] wdata_q;
   logic done_q;
   logic err_q;
   logic [31:0] prdata_q;

   logic a_we;
   logic [7:0] a_addr;
   logic [2:0] a_len;
   logic [31:0] a_data;
   logic in_access;
   logic adv;
   logic busy;
   logic apb_acc;
   logic mapped;
   logic start;

   assign busy = (state_q != HS_IDLE);
   assign in_access = busy && state_q != HS_SETTLE;
   assign adv = req_q && link.ack;

   always_comb begin
      a_we = 1'b1;
      a_addr = OFS_PAGE;
      a_len = LEN_BYTE;
      a_data = {24'h00_0000, PAGE_BASE};
      case (state_q)
         HS_BK0: begin
            a_addr = OFS_BOOK;
            a_data = {24'h00_0000, BOOK_BASE};
         end
         HS_ACT: begin
            a_addr = OFS_POWER;
            a_data = {24'h00_0000, PWR_ACTIVE};
         end
         HS_PG1A: begin
            a_data = {24'h00_0000, PAGE_CMD};
         end
         HS_CMD: begin
            a_addr = OFS_CMD;
            a_len = LEN_WORD;
            a_data = code_q;
         end
         HS_FLAG: begin
            a_addr = OFS_FLAG;
            a_len = LEN_WORD;
            a_data = FLAG_NEW;
         end
         HS_POLL: begin
            a_we = 1'b0;
            a_addr = OFS_FLAG;
            a_len = LEN_WORD;
            a_data = 32'h0000_0000;
         end
         HS_SHUT: begin
            a_addr = OFS_POWER;
            a_data = {24'h00_0000, PWR_SHUTDOWN};
         end
         default: begin
            a_we = 1'b1;
         end
      endcase
   end

   // One gap cycle between requests lets the device ack fall
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         req_q <= 1'b0;
         we_q <= 1'b0;
         addr_q <= 8'h00;
         len_q <= 3'h0;
         wdata_q <= 32'h0000_0000;
      end else if (ce) begin
         if (adv) begin
            req_q <= 1'b0;
         end else if (in_access && !req_q) begin
            req_q <= 1'b1;
            we_q <= a_we;
            addr_q <= a_addr;
            len_q <= a_len;
            wdata_q <= a_data;
         end
      end
   end

   assign apb_acc = psel & penable;
   assign mapped = paddr == APB_CMD || paddr == APB_STATUS
      || paddr == APB_LAST;
   assign start = ce && apb_acc && pwrite && paddr == APB_CMD && !busy;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= HS_IDLE;
         cnt_q <= 32'h0000_0000;
      end else if (ce) begin
         case (state_q)
            HS_IDLE: begin
               if (start) begin
                  state_q <= HS_PG0;
               end
            end
            HS_SETTLE: begin
               if (cnt_q == SETTLE_CYCLES - 1) begin
                  state_q <= HS_PG1A;
               end else begin
                  cnt_q <= cnt_q + 32'h0000_0001;
               end
            end
            default: begin
               if (adv && link.err) begin
                  state_q <= HS_IDLE;
               end else if (adv) begin
                  case (state_q)
                     HS_PG0: state_q <= HS_BK0;
                     HS_BK0: state_q <= HS_ACT;
                     HS_ACT: begin
                        state_q <= HS_SETTLE;
                        cnt_q <= 32'h0000_0000;
                     end
                     HS_PG1A: state_q <= HS_CMD;
                     HS_CMD: state_q <= HS_FLAG;
                     HS_FLAG: state_q <= HS_POLL;
                     HS_POLL: begin
                        if (link.rdata == 32'h0000_0000) begin
                           state_q <= HS_PG0B;
                        end
                     end
                     HS_PG0B: state_q <= HS_SHUT;
                     default: state_q <= HS_IDLE;
                  endcase
               end
            end
         endcase
      end
   end

   // Done and error are cleared by the next start, set by sequence end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done_q <= 1'b0;
         err_q <= 1'b0;
         code_q <= 32'h0000_0000;
      end else if (ce) begin
         if (start) begin
            done_q <= 1'b0;
            err_q <= 1'b0;
            code_q <= pwdata;
         end else if (adv && link.err) begin
            err_q <= 1'b1;
         end else if (adv && state_q == HS_SHUT) begin
            done_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
      end else if (ce && psel && !penable) begin
         prdata_q <= 32'h0000_0000;
         if (paddr == APB_STATUS) begin
            prdata_q[ST_BUSY] <= busy;
            prdata_q[ST_DONE] <= done_q;
            prdata_q[ST_ERR] <= err_q;
            prdata_q[ST_STATE +: 4] <= state_q;
         end else if (paddr == APB_LAST) begin
            prdata_q <= code_q;
         end
      end
   end

   assign prdata = prdata_q;
   assign pready = 1'b1;
   assign pslverr = apb_acc
      && (!mapped || (pwrite && paddr == APB_CMD && busy)
          || (pwrite && paddr != APB_CMD));
   assign link.req = req_q;
   assign link.we = we_q;
   assign link.addr = addr_q;
   assign link.len = len_q;
   assign link.wdata = wdata_q;
endmodule

// ### hcr_link_sva.sv
// Checker for the link joining the host end to the device end.
// Assumes both ends are design code and share one pclk domain.
`timescale 1ns/1ps
module hcr_link_sva #(
   parameter int unsigned SETTLE_CYCLES = hcr_pkg::SETTLE_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic req,
   input wire logic we,
   input wire logic [hcr_pkg::LINK_AW-1:0] addr,
   input wire logic [2:0] len,
   input wire logic [hcr_pkg::DW-1:0] wdata,
   input wire logic ack,
   input wire logic err,
   input wire logic [hcr_pkg::DW-1:0] rdata
);
   import hcr_pkg::*;
   logic [7:0] page_q;
   logic [7:0] book_q;
   logic pend_q;
   logic act_q;
   logic [31:0] quiet_q;
   wire logic wr_ok = ack && we && !err;
   wire logic wake = wr_ok && addr == OFS_POWER && wdata[7:0] == PWR_ACTIVE;

   // Window as the device sees it, from accepted writes only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         page_q <= RST_PAGE;
         book_q <= RST_BOOK;
      end else if (wr_ok && addr == OFS_PAGE) begin
         page_q <= wdata[7:0];
      end else if (wr_ok && addr == OFS_BOOK) begin
         book_q <= wdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_q <= 1'b0;
      end else if (wr_ok && addr == OFS_FLAG && wdata == FLAG_NEW) begin
         pend_q <= 1'b1;
      end else if (ack && !we && !err && addr == OFS_FLAG && rdata == '0) begin
         pend_q <= 1'b0;
      end
   end

   // Idle cycles since the wake write; stops at the next request
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         act_q <= 1'b0;
         quiet_q <= '0;
      end else if (wake) begin
         act_q <= 1'b1;
         quiet_q <= '0;
      end else if (req) begin
         act_q <= 1'b0;
      end else if (act_q) begin
         quiet_q <= quiet_q + 32'h0000_0001;
      end
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   property p_ack_next; $rose(req) |=> ack; endproperty
   a_ack_next: assert property (p_ack_next) else $error("ack late");
   property p_ack_end; ack |=> !ack && !req; endproperty
   a_ack_end: assert property (p_ack_end) else $error("ack or req held");
   property p_req_hold;
      req && !ack |=> req && $stable({we, addr, len, wdata});
   endproperty
   a_req_hold: assert property (p_req_hold) else $error("request moved");
   property p_wr_rdata; ack && we |-> rdata == '0 && !err; endproperty
   a_wr_rdata: assert property (p_wr_rdata) else $error("write answer");
   property p_len;
      req |-> len == ((addr == OFS_CMD || addr == OFS_FLAG)
         ? LEN_WORD : LEN_BYTE);
   endproperty
   a_len: assert property (p_len) else $error("length mismatch");
   property p_cmd_win;
      req && we && (addr == OFS_CMD || addr == OFS_FLAG)
         |-> page_q == PAGE_CMD && book_q == BOOK_BASE;
   endproperty
   a_cmd_win: assert property (p_cmd_win) else $error("command page");
   property p_pwr_win;
      req && addr == OFS_POWER |-> page_q == PAGE_BASE && book_q == BOOK_BASE;
   endproperty
   a_pwr_win: assert property (p_pwr_win) else $error("power page");
   property p_settle;
      $rose(req) && act_q |-> quiet_q >= SETTLE_CYCLES - 1;
   endproperty
   a_settle: assert property (p_settle) else $error("settle short");
   property p_poll;
      req && we && addr == OFS_PAGE && wdata[7:0] == PAGE_BASE |-> !pend_q;
   endproperty
   a_poll: assert property (p_poll) else $error("left before clear");
   property p_rd_err; ack && err |-> rdata == '0; endproperty
   a_rd_err: assert property (p_rd_err) else $error("error data");
   property p_flag_rd;
      ack && !we && !err && addr == OFS_FLAG |-> rdata[31:1] == '0;
   endproperty
   a_flag_rd: assert property (p_flag_rd) else $error("flag data");
   c_cmd: cover property (ack && we && addr == OFS_CMD);
   c_clear: cover property (ack && !we && addr == OFS_FLAG && rdata == '0);
   c_settle: cover property ($rose(req) && act_q);
endmodule

// ### tb_top.sv
// Top bench: APB drives host end into device A; a bench link driver
// works device B directly. Assumes shortened settle and run counts.
`timescale 1ns/1ps
module tb_top;
   import hcr_pkg::*;
   localparam int unsigned EXEC = 10;
   localparam int unsigned SETTLE = 20;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [4:0] set_a = 5'h00;
   logic [4:0] set_b = 5'h00;
   logic start_b = 1'b0;
   logic [NPARAM*DW-1:0] wp_a;
   logic [NPARAM*DW-1:0] wp_b;
   logic [4:0] st_a;
   logic [4:0] st_b;
   logic pw_a;
   logic pw_b;
   logic busy_a;
   logic busy_b;
   logic [31:0] seed = 32'h5692_1ff6;
   int fails = 0;
   int compares = 0;
   hcr_link_if link_a (.pclk(pclk));
   hcr_link_if link_b (.pclk(pclk));
   hcr_host #(.SETTLE_CYCLES(SETTLE)) u_hcr_host (.pclk(pclk),
      .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .link(link_a.host));
   hcr_device #(.EXEC_CYCLES(EXEC)) u_hcr_device (.pclk(pclk),
      .presetn(presetn), .ce(1'b1), .link(link_a.dev), .start_mode(1'b0),
      .flag_set(set_a), .work_params(wp_a), .sticky_flags(st_a),
      .power_active(pw_a), .cmd_busy(busy_a));
   hcr_device #(.EXEC_CYCLES(EXEC)) u_hcr_device_b (.pclk(pclk),
      .presetn(presetn), .ce(1'b1), .link(link_b.dev), .start_mode(start_b),
      .flag_set(set_b), .work_params(wp_b), .sticky_flags(st_b),
      .power_active(pw_b), .cmd_busy(busy_b));
   hcr_link_sva #(.SETTLE_CYCLES(SETTLE)) u_hcr_link_sva (.pclk(pclk),
      .presetn(presetn), .req(link_a.req), .we(link_a.we),
      .addr(link_a.addr), .len(link_a.len), .wdata(link_a.wdata),
      .ack(link_a.ack), .err(link_a.err), .rdata(link_a.rdata));

   always #2 pclk = ~pclk;

   function automatic logic [31:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction

   task automatic print_verdict();
      $display("compares=%0d fails=%0d", compares, fails);
      if (fails == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task automatic timeout();
      fails++;
      $display("ERROR t=%0t wait limit got=%h exp=%h", $time, 1'b0, 1'b1);
      print_verdict();
   endtask

   task automatic chk_data(input logic [127:0] g, input logic [127:0] e);
      compares++;
      if (g !== e) begin
         fails++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic chk_bit(input logic g, input logic e);
      compares++;
      if (g !== e) begin
         fails++;
         $display("ERROR t=%0t flag got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d, output logic [31:0] rd, output logic er);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~d;
      if (pready !== 1'b1) timeout();
   endtask

   task automatic aw(input logic [7:0] a, input logic [31:0] d, input logic e);
      logic [31:0] rd;
      logic er;
      apb(1'b1, a, d, rd, er);
      chk_bit(er, e);
   endtask

   task automatic ar(input logic [7:0] a, input logic [31:0] x, input logic e);
      logic [31:0] rd;
      logic er;
      apb(1'b0, a, 32'h0000_0000, rd, er);
      chk_bit(er, e);
      chk_data(rd, x);
   endtask

   // Bench stands in for the host on the second link
   task automatic lk(input logic w, input logic [7:0] a, input logic [2:0] l,
         input logic [31:0] d, output logic [31:0] rd, output logic er);
      int n;
      @(posedge pclk);
      link_b.req <= 1'b1;
      link_b.we <= w;
      link_b.addr <= a;
      link_b.len <= l;
      link_b.wdata <= d;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (link_b.ack !== 1'b1 && n < 20);
      rd = link_b.rdata;
      er = link_b.err;
      link_b.req <= 1'b0;
      link_b.wdata <= ~d;
      if (er === 1'bx || n >= 20) timeout();
   endtask

   task automatic lwr(input logic [7:0] a, input logic [2:0] l,
         input logic [31:0] d, input logic e);
      logic [31:0] rd;
      logic er;
      lk(1'b1, a, l, d, rd, er);
      chk_bit(er, e);
   endtask

   task automatic lrd(input logic [7:0] a, input logic [2:0] l,
         input logic [31:0] x, input logic e);
      logic [31:0] rd;
      logic er;
      lk(1'b0, a, l, 32'h0000_0000, rd, er);
      chk_bit(er, e);
      chk_data(rd, x);
   endtask

   task automatic b_cmd(input logic [31:0] code);
      logic [31:0] rd;
      logic er;
      int n;
      lwr(OFS_CMD, LEN_WORD, code, 1'b0);
      lwr(OFS_FLAG, LEN_WORD, FLAG_NEW, 1'b0);
      lrd(OFS_FLAG, LEN_WORD, FLAG_NEW, 1'b0);
      chk_bit(busy_b, 1'b1);
      n = 0;
      do begin
         lk(1'b0, OFS_FLAG, LEN_WORD, 32'h0000_0000, rd, er);
         n++;
      end while (rd !== 32'h0000_0000 && n < 8);
      chk_data(rd, 32'h0000_0000);
      chk_bit(busy_b, 1'b0);
   endtask

   task automatic run_cmd(input logic [31:0] code);
      logic [31:0] rd;
      logic er;
      int n;
      aw(APB_CMD, code, 1'b0);
      aw(APB_CMD, code, 1'b1);
      ar(APB_LAST, code, 1'b0);
      n = 0;
      do begin
         apb(1'b0, APB_STATUS, 32'h0000_0000, rd, er);
         n++;
      end while (rd[ST_BUSY] !== 1'b0 && n < 200);
      if (n >= 200) timeout();
      chk_data(rd, 32'h0000_0002);
   endtask

   initial begin
      logic [31:0] v;
      logic [31:0] code;
      logic [4:0] ex;
      logic [127:0] pv;
      link_b.req = 1'b0;
      link_b.we = 1'b0;
      link_b.addr = 8'h00;
      link_b.len = 3'h0;
      link_b.wdata = 32'h0000_0000;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      ar(APB_STATUS, 32'h0000_0000, 1'b0);
      chk_bit(pw_a, 1'b0);
      ex = 5'h00;
      for (int i = 0; i < 3; i++) begin
         v = rnd();
         code = (i == 0) ? CMD_CLEAR : (i == 1) ? CMD_REINIT
            : {24'h00_0000, v[7:4], 4'h3};
         @(posedge pclk);
         set_a <= v[4:0] | 5'h01;
         @(posedge pclk);
         set_a <= 5'h00;
         @(posedge pclk);
         ex = ex | v[4:0] | 5'h01;
         chk_data(st_a, ex);
         run_cmd(code);
         if (code == CMD_CLEAR) ex = 5'h00;
         chk_data(st_a, ex);
         chk_bit(pw_a, 1'b0);
         chk_bit(busy_a, 1'b0);
         chk_data(wp_a, '0);
      end
      ar(8'h0C, 32'h0000_0000, 1'b1);
      aw(APB_STATUS, 32'h0000_0001, 1'b1);
      // Second reset, with both ends idle, clears the sticky state left above
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      chk_data(st_a, '0);
      lrd(OFS_PAGE, LEN_BYTE, {24'h00_0000, RST_PAGE}, 1'b0);
      lrd(OFS_PAGE, LEN_WORD, 32'h0000_0000, 1'b1);
      lwr(OFS_BOOK, LEN_BYTE, 32'h0000_0000, 1'b0);
      lrd(OFS_POWER, LEN_BYTE, {24'h00_0000, RST_POWER}, 1'b0);
      lwr(OFS_POWER, LEN_WORD, 32'h0000_0000, 1'b1);
      chk_bit(pw_b, 1'b0);
      lwr(OFS_POWER, LEN_BYTE, 32'h0000_0000, 1'b0);
      chk_bit(pw_b, 1'b1);
      lwr(OFS_PAGE, LEN_BYTE, {24'h00_0000, PAGE_CMD}, 1'b0);
      lrd(OFS_PAGE, LEN_BYTE, {24'h00_0000, PAGE_CMD}, 1'b0);
      lrd(OFS_POWER, LEN_BYTE, 32'h0000_0000, 1'b1);
      for (int i = 0; i < NPARAM; i++) begin
         pv[32*i+:32] = rnd();
         lwr(OFS_PARAM0 + OFS_STEP * 8'(i), LEN_WORD, pv[32*i+:32],
            1'b0);
      end
      chk_data(wp_b, '0);
      b_cmd(CMD_REINIT);
      chk_data(wp_b, pv);
      v = pv[31:0];
      pv[31:0] = rnd();
      lwr(OFS_PARAM0, LEN_WORD, pv[31:0], 1'b0);
      chk_data(wp_b, {pv[127:32], v});
      @(posedge pclk);
      start_b <= 1'b1;
      @(posedge pclk);
      start_b <= 1'b0;
      @(posedge pclk);
      chk_data(wp_b, pv);
      v = rnd() | 32'h0000_0001;
      @(posedge pclk);
      set_b <= v[4:0];
      @(posedge pclk);
      set_b <= 5'h00;
      for (int i = 0; i < NSTICKY; i++) begin
         lrd(OFS_STICKY0 + OFS_STEP * 8'(i), LEN_WORD, {31'h0, v[i]},
            1'b0);
      end
      b_cmd(CMD_CLEAR);
      chk_data(st_b, '0);
      lwr(OFS_PAGE, LEN_BYTE, 32'h0000_0000, 1'b0);
      lwr(OFS_BOOK, LEN_BYTE, 32'h0000_0001, 1'b0);
      lrd(OFS_POWER, LEN_BYTE, 32'h0000_0000, 1'b1);
      print_verdict();
   end
endmodule
